// ===== ftcc_capture_trig.sv
/*
 * Synchroniser and edge selector for the capture input pin.
 * Assumes the pin is asynchronous to clock; emits a one-cycle pulse.
 */
`timescale 1ns/1ns
module ftcc_capture_trig
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Pin and selection
    input wire logic trigger_in_pin,
    input wire ftcc_pkg::ftcc_edge_t edge_sel,
    // Result
    output logic capture_pulse
);
    import ftcc_pkg::*;

    logic sync_a;
    logic sync_b;
    logic sync_c;
    logic rise;
    logic fall;
    logic next_capture;

    // Two flops before any logic; third flop only for edge detection
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            sync_c <= 1'b0;
            capture_pulse <= 1'b0;
        end
        else
        begin
            sync_a <= trigger_in_pin;
            sync_b <= sync_a;
            sync_c <= sync_b;
            capture_pulse <= next_capture;
        end
    end

    // Edge decode from the settled stages only
    assign rise = sync_b & ~sync_c;
    assign fall = ~sync_b & sync_c;
    assign next_capture = ((edge_sel == FTCC_EDGE_RISE) & rise)
                        | ((edge_sel == FTCC_EDGE_FALL) & fall)
                        | ((edge_sel == FTCC_EDGE_BOTH) & (rise | fall));

endmodule // ftcc_capture_trig

// ===== ftcc_cpu_model.sv
/* CPU side model for the timer memory port.
   Assumes its tasks are called at the falling clock edge. */
`timescale 1ns/1ns
module ftcc_cpu_model
(
    // Clock
    input wire logic clock,
    // Requests
    output logic [15:0] bus_addr,
    output logic bus_wr,
    output logic bus_rd,
    output logic bus_word,
    output logic [15:0] bus_wdata,
    // Answer
    input wire logic [15:0] bus_rdata
);
    // ----------------------------------------
    // Bus cycles
    // ----------------------------------------
    // Released lines show inverted values so stale data never looks valid
    task automatic idle();
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        bus_addr = ~bus_addr;
        bus_wdata = ~bus_wdata;
    endtask
    // One access held for one cycle; a read answer is taken a cycle later
    task automatic xfer(input logic [15:0] a, input logic w, input logic r,
        input logic [15:0] d, output logic [15:0] q);
        bus_addr = a;
        bus_word = w;
        bus_rd = r;
        bus_wr = !r;
        bus_wdata = d;
        @(negedge clock);
        q = bus_rdata;
    endtask
    // Quiet bus at time zero
    initial
    begin
        bus_addr = 16'hFFFF;
        bus_word = 1'b0;
        bus_wdata = 16'hFFFF;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
    end
endmodule // ftcc_cpu_model

// ===== ftcc_defines.svh
/*
 * Offsets, field positions, reset values and divider figures of the
 * free-running timer with capture and compare.
 * Assumes inclusion by bare name from the checker, the timer top and the bench.
 */
`ifndef FTCC_DEFINES_SVH
`define FTCC_DEFINES_SVH

// ----------------------------------------------------------------------
// Register byte addresses on the CPU memory port
// ----------------------------------------------------------------------
`define FTCC_ADDR_MATCH_LO 16'hFF10
`define FTCC_ADDR_MATCH_HI 16'hFF11
`define FTCC_ADDR_COUNT_LO 16'hFF14
`define FTCC_ADDR_COUNT_HI 16'hFF15
`define FTCC_ADDR_SNAP_LO 16'hFF16
`define FTCC_ADDR_SNAP_HI 16'hFF17
`define FTCC_ADDR_MODE 16'hFF48

// ----------------------------------------------------------------------
// Mode register fields
// ----------------------------------------------------------------------
`define FTCC_MODE_OUT_DATA 7
`define FTCC_MODE_WRAP 6
`define FTCC_MODE_EDGE_HI 5
`define FTCC_MODE_EDGE_LO 4
`define FTCC_MODE_TOGGLE_EN 3
`define FTCC_MODE_DIV_HI 2
`define FTCC_MODE_DIV_LO 1
`define FTCC_MODE_OUT_EN 0

// ----------------------------------------------------------------------
// Reset values and counter maximum
// ----------------------------------------------------------------------
`define FTCC_RST_MATCH 16'hFFFF
`define FTCC_RST_COUNT 16'h0000
`define FTCC_RST_MODE 8'h00
`define FTCC_COUNT_MAX 16'hFFFF

// ----------------------------------------------------------------------
// Count clock prescaler: masks of the low prescaler bits for /4, /32, /128
// ----------------------------------------------------------------------
`define FTCC_PRE_W 7
`define FTCC_PRE_MASK_DIV4 7'h03
`define FTCC_PRE_MASK_DIV32 7'h1F
`define FTCC_PRE_MASK_DIV128 7'h7F

`endif

// ===== ftcc_pkg.sv
/*
 * Types shared by the timer modules.
 * Assumes ftcc_defines.svh holds the numeric constants.
 */
package ftcc_pkg;

    // Capture trigger selection
    typedef enum logic [1:0] {
        FTCC_EDGE_OFF = 2'h0,
        FTCC_EDGE_RISE = 2'h1,
        FTCC_EDGE_FALL = 2'h2,
        FTCC_EDGE_BOTH = 2'h3
    } ftcc_edge_t;

    // Count clock selection
    typedef enum logic [1:0] {
        FTCC_DIV_1 = 2'h0,
        FTCC_DIV_4 = 2'h1,
        FTCC_DIV_32 = 2'h2,
        FTCC_DIV_128 = 2'h3
    } ftcc_div_t;

endpackage

// ===== ftcc_timer_properties.sv
/* Port checker for the timer.
   Assumes it is bound into ftcc_top, one clock domain. */
`timescale 1ns/1ns
`include "ftcc_defines.svh"
module ftcc_timer_properties
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Watched ports
    input wire logic [15:0] bus_addr,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic bus_word,
    input wire logic [15:0] bus_wdata,
    input wire logic [15:0] bus_rdata,
    input wire logic bus_rvalid,
    input wire logic toggle_out_pin,
    input wire logic toggle_out_oe,
    input wire logic match_irq
);
    // ----------------------------------------
    // Helper decode
    // ----------------------------------------
    logic [1:0] div_seen;
    logic mode_wr;
    logic cnt_rd;
    assign mode_wr = bus_wr && !bus_word && bus_addr == `FTCC_ADDR_MODE;
    assign cnt_rd = bus_rd && bus_word && (bus_addr | 16'h0001) == `FTCC_ADDR_COUNT_HI;
    // Mirrors the divider so the step check only runs at full rate
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            div_seen <= 2'h0;
        else if (mode_wr)
            div_seen <= bus_wdata[2:1];
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_read_answered: assert property (bus_rd |=> bus_rvalid)
        else $error("read not answered");
    a_answer_needs_read: assert property (bus_rvalid |-> $past(bus_rd))
        else $error("answer without read");
    a_byte_upper_zero: assert property (bus_rvalid && !$past(bus_word)
        |-> bus_rdata[15:8] == 8'h00) else $error("byte read upper not zero");
    a_rdata_holds: assert property (!$past(bus_rd) |-> $stable(bus_rdata))
        else $error("read data moved");
    a_irq_single_pulse: assert property (match_irq |=> !match_irq)
        else $error("match request too long");
    a_pin_on_match: assert property ($changed(toggle_out_pin) |-> match_irq)
        else $error("output moved without match");
    a_oe_follows_mode: assert property (mode_wr && bus_wdata[0]
        |=> ##[0:1] toggle_out_oe) else $error("output enable missing");
    a_count_steps_one: assert property (cnt_rd && div_seen == 2'h0 ##1 cnt_rd
        |=> bus_rdata == $past(bus_rdata) + 16'h0001) else $error("count did not step");
endmodule // ftcc_timer_properties

bind ftcc_top ftcc_timer_properties chk_u (.clock, .rst_n, .bus_addr, .bus_wr, .bus_rd,
    .bus_word, .bus_wdata, .bus_rdata, .bus_rvalid, .toggle_out_pin, .toggle_out_oe,
    .match_irq);

// ===== ftcc_top.sv
/*
 * Free-running 16-bit timer with one compare and one capture register,
 * a counter read buffer and a CPU memory port with byte and word access.
 * Assumes a single 25 MHz clock; interrupt masking lives in the CPU's
 * interrupt controller outside this block.
 */
// Summary of operation
// - 16-bit counter advances per count pulse; reset clears it, then counting resumes.
// - Counter equal to compare value raises the match interrupt request.
// - Compare accepts any 16-bit value; reset loads all ones.
// - Capture trigger latches the counter into the capture register, held till next.
// - Capture register is not reset; undefined until first capture.
// - Timer output can follow compare match events.
// - Compare, counter, capture accept 16-bit and 8-bit accesses.
// - A read buffer latches the counter for a consistent snapshot.
// - Counter is readable by word access and cannot be loaded by software.
// - Counter keeps counting during stabilisation; its value then is undefined.
// - Two-bit clock field selects main clock divided by 1, 4, 32 or 128.
// - Overflow sets a flag cleared only by reset or a software write.
// - With toggling enabled a match inverts the output pin; counting continues.
`timescale 1ns/1ns
`include "ftcc_defines.svh"
module ftcc_top
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // CPU memory port
    input wire logic [15:0] bus_addr,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic bus_word,
    input wire logic [15:0] bus_wdata,
    output logic [15:0] bus_rdata,
    output logic bus_rvalid,
    // Pins and events
    input wire logic trigger_in_pin,
    output logic toggle_out_pin,
    output logic toggle_out_oe,
    output logic match_irq
);
    import ftcc_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [15:0] free_counter;
    logic [15:0] match_value_reg;
    logic [15:0] snapshot_reg;
    logic [15:0] read_buffer;
    logic [`FTCC_PRE_W-1:0] prescale;
    logic wrap_flag;
    logic toggle_enable;
    logic out_enable;
    logic out_data;
    ftcc_edge_t edge_sel;
    ftcc_div_t clk_div_sel;
    logic capture_pulse;
    // Mode reset image, sliced per field so each typed field gets a constant
    localparam logic [7:0] mode_reset = `FTCC_RST_MODE;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Count pulse from the prescaler for a given divider choice
    function automatic logic div_tick(input ftcc_div_t sel,
                                      input logic [`FTCC_PRE_W-1:0] pre);
        logic t;
        t = 1'b1;
        case (sel)
            FTCC_DIV_1: t = 1'b1;
            FTCC_DIV_4: t = (pre & `FTCC_PRE_MASK_DIV4) == `FTCC_PRE_MASK_DIV4;
            FTCC_DIV_32: t = (pre & `FTCC_PRE_MASK_DIV32) == `FTCC_PRE_MASK_DIV32;
            FTCC_DIV_128: t = (pre & `FTCC_PRE_MASK_DIV128) == `FTCC_PRE_MASK_DIV128;
            default: t = 1'b1;
        endcase
        return t;
    endfunction

    // Address match ignoring the byte bit for word accesses
    function automatic logic hit(input logic [15:0] addr, input logic word,
                                 input logic [15:0] target);
        return word ? (addr[15:1] == target[15:1]) : (addr == target);
    endfunction

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    wire wr_match_lo = bus_wr & hit(bus_addr, bus_word, `FTCC_ADDR_MATCH_LO);
    wire wr_match_hi = bus_wr & (bus_word ? wr_match_lo : bus_addr == `FTCC_ADDR_MATCH_HI);
    wire wr_mode = bus_wr & ~bus_word & (bus_addr == `FTCC_ADDR_MODE);
    wire rd_count_lo = bus_rd & hit(bus_addr, bus_word, `FTCC_ADDR_COUNT_LO);
    wire rd_count_hi = bus_rd & ~bus_word & (bus_addr == `FTCC_ADDR_COUNT_HI);
    wire [7:0] wbyte = bus_word ? bus_wdata[15:8] : bus_wdata[7:0];

    // New compare value after this cycle's write, byte lanes merged
    wire [15:0] next_match = {wr_match_hi ? wbyte : match_value_reg[15:8],
                              wr_match_lo ? bus_wdata[7:0] : match_value_reg[7:0]};

    // ------------------------------------------------------------------
    // Counting and match
    // ------------------------------------------------------------------
    wire tick = div_tick(clk_div_sel, prescale);
    wire [15:0] next_count = tick ? free_counter + 16'h0001 : free_counter;
    wire overflow = tick & (free_counter == `FTCC_COUNT_MAX);
    // A match event fires on reaching the compare value, and also when a
    // rewrite lands on the current count; that is why software must mask first.
    wire match_event = (next_count == next_match)
                     & (tick | wr_match_lo | wr_match_hi);
    wire next_out = (toggle_enable & match_event) ? ~out_data : out_data;
    wire next_wrap = overflow | (wrap_flag & ~(wr_mode & ~bus_wdata[`FTCC_MODE_WRAP]));

    // Counter and prescaler; counter is not writable from the bus
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prescale <= '0;
            free_counter <= `FTCC_RST_COUNT;
        end
        else
        begin
            prescale <= prescale + 7'h01;
            free_counter <= next_count;
        end
    end

    // Compare register
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            match_value_reg <= `FTCC_RST_MATCH;
        else
            match_value_reg <= next_match;
    end

    // Mode fields, overflow flag (set beats a clearing write) and output pin
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            edge_sel <= ftcc_edge_t'(mode_reset[`FTCC_MODE_EDGE_HI:`FTCC_MODE_EDGE_LO]);
            toggle_enable <= mode_reset[`FTCC_MODE_TOGGLE_EN];
            clk_div_sel <= ftcc_div_t'(mode_reset[`FTCC_MODE_DIV_HI:`FTCC_MODE_DIV_LO]);
            out_enable <= mode_reset[`FTCC_MODE_OUT_EN];
            wrap_flag <= 1'b0;
            out_data <= 1'b0;
            toggle_out_pin <= 1'b0;
            toggle_out_oe <= 1'b0;
            match_irq <= 1'b0;
        end
        else
        begin
            if (wr_mode)
            begin
                edge_sel <= ftcc_edge_t'(bus_wdata[`FTCC_MODE_EDGE_HI:`FTCC_MODE_EDGE_LO]);
                toggle_enable <= bus_wdata[`FTCC_MODE_TOGGLE_EN];
                clk_div_sel <= ftcc_div_t'(bus_wdata[`FTCC_MODE_DIV_HI:`FTCC_MODE_DIV_LO]);
                out_enable <= bus_wdata[`FTCC_MODE_OUT_EN];
            end
            wrap_flag <= next_wrap;
            out_data <= next_out;
            toggle_out_pin <= next_out;
            toggle_out_oe <= wr_mode ? bus_wdata[`FTCC_MODE_OUT_EN] : out_enable;
            match_irq <= match_event;
        end
    end

    // ------------------------------------------------------------------
    // Capture
    // ------------------------------------------------------------------
    ftcc_capture_trig u_capture_trig
    (
        .clock(clock),
        .rst_n(rst_n),
        .trigger_in_pin(trigger_in_pin),
        .edge_sel(edge_sel),
        .capture_pulse(capture_pulse)
    );

    // No reset: content is meaningless until the first trigger
    always_ff @(posedge clock)
    begin
        if (capture_pulse)
            snapshot_reg <= free_counter;
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    // Read buffer freezes the whole count at the low-byte or word read,
    // so the later high-byte read cannot see a carry in between.
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            read_buffer <= `FTCC_RST_COUNT;
        else if (rd_count_lo)
            read_buffer <= free_counter;
    end

    wire [7:0] mode_byte = {out_data, wrap_flag, edge_sel, toggle_enable, clk_div_sel, out_enable};
    wire [15:0] word_sel =
        hit(bus_addr, bus_word, `FTCC_ADDR_MATCH_LO) ? match_value_reg :
        hit(bus_addr, bus_word, `FTCC_ADDR_COUNT_LO) ? free_counter :
        hit(bus_addr, bus_word, `FTCC_ADDR_SNAP_LO) ? snapshot_reg : 16'h0000;
    // Byte reads: low bytes live, high byte of the counter from the buffer
    wire [7:0] byte_sel =
        (bus_addr == `FTCC_ADDR_MATCH_LO) ? match_value_reg[7:0] :
        (bus_addr == `FTCC_ADDR_MATCH_HI) ? match_value_reg[15:8] :
        (bus_addr == `FTCC_ADDR_COUNT_LO) ? free_counter[7:0] :
        rd_count_hi ? read_buffer[15:8] :
        (bus_addr == `FTCC_ADDR_SNAP_LO) ? snapshot_reg[7:0] :
        (bus_addr == `FTCC_ADDR_SNAP_HI) ? snapshot_reg[15:8] :
        (bus_addr == `FTCC_ADDR_MODE) ? mode_byte : 8'h00;
    wire [15:0] next_rdata = bus_word ? word_sel : {8'h00, byte_sel};

    // Registered read data, one cycle after the strobe
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bus_rdata <= 16'h0000;
            bus_rvalid <= 1'b0;
        end
        else
        begin
            bus_rdata <= bus_rd ? next_rdata : bus_rdata;
            bus_rvalid <= bus_rd;
        end
    end

    // Counting never pauses for stop-release stabilisation; count then is arbitrary.
    // Compare rewrite hazard is left to software masking.

endmodule // ftcc_top

// ===== test_free_running_timer_capture_compare.sv
/* Self-checking bench for the free-running timer.
   Assumes ftcc_top, the CPU model and the checker are compiled first. */
`timescale 1ns/1ns
`include "ftcc_defines.svh"
module test_free_running_timer_capture_compare;
    // ----------------------------------------
    // Signals and tables
    // ----------------------------------------
    logic clock, rst_n, trigger_in_pin, bus_wr, bus_rd, bus_word, bus_rvalid;
    logic toggle_out_pin, toggle_out_oe, match_irq;
    logic [15:0] bus_addr, bus_wdata, bus_rdata, w1, w2, q, hi, c, cap;
    logic [16:0] n;
    int fail_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    localparam logic [15:0] ad_cnt = `FTCC_ADDR_COUNT_LO;
    localparam logic [15:0] ad_mode = `FTCC_ADDR_MODE;
    // Reads after reset: address, word flag, value
    localparam logic [32:0] rows [5] = '{{`FTCC_ADDR_MATCH_LO, 1'b1, `FTCC_RST_MATCH},
        {`FTCC_ADDR_MATCH_LO, 1'b0, 16'h00FF}, {`FTCC_ADDR_MATCH_HI, 1'b0, 16'h00FF},
        {`FTCC_ADDR_MODE, 1'b0, 16'h0000}, {16'hFF20, 1'b1, 16'h0000}};
    localparam logic [1:0] edges [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
    // Ticks in a 256-cycle window for divide by 1, 4, 32 and 128
    localparam logic [15:0] steps [4] = '{16'h0100, 16'h0040, 16'h0008, 16'h0002};

    ftcc_top dut_u (.clock, .rst_n, .bus_addr, .bus_wr, .bus_rd, .bus_word, .bus_wdata,
        .bus_rdata, .bus_rvalid, .trigger_in_pin, .toggle_out_pin, .toggle_out_oe, .match_irq);
    ftcc_cpu_model cpu_u (.clock, .bus_addr, .bus_wr, .bus_rd, .bus_word, .bus_wdata, .bus_rdata);

    // ----------------------------------------
    // Clock, timeout and helpers
    // ----------------------------------------
    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    // The run needs about 67k cycles, so a hang is cut at 90k cycles
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 90000)
        begin
            fail_count++;
            report_and_stop();
        end
    end
    task automatic check(input logic [16:0] seen, input logic [16:0] want);
        samples_checked++;
        if (seen !== want)
        begin
            fail_count++;
            $display("unexpected at %0t: seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic rd(input logic [15:0] a, input logic w, output logic [15:0] v);
        cpu_u.xfer(a, w, 1'b1, 16'h0000, v);
    endtask
    task automatic wr(input logic [15:0] a, input logic w, input logic [15:0] d);
        cpu_u.xfer(a, w, 1'b0, d, q);
    endtask
    // Counts falling edges until a match request, bounded
    task automatic wait_irq(input int lim);
        n = 17'h00000;
        do
        begin
            @(negedge clock);
            n++;
        end
        while (match_irq !== 1'b1 && n < lim);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        rst_n = 1'b0;
        trigger_in_pin = 1'b0;
        repeat (20) @(negedge clock);
        check({14'h0, toggle_out_pin, toggle_out_oe, match_irq}, 17'h0);
        rst_n = 1'b1;
        foreach (rows[i])
        begin
            rd(rows[i][32:17], rows[i][16], q);
            check(q, rows[i][15:0]);
        end
        $display("test reset values done");
        // Back-to-back reads, a byte pair split by a long gap, an ignored write
        rd(ad_cnt, 1'b1, w1);
        rd(ad_cnt, 1'b1, w2);
        rd(ad_cnt, 1'b0, q);
        cpu_u.idle();
        c = w1 + 16'h0002;
        check(w2, w1 + 16'h0001);
        check(q, c[7:0]);
        repeat (300) @(negedge clock);
        rd(ad_cnt + 16'h0001, 1'b0, hi);
        wr(ad_cnt, 1'b1, 16'h0000);
        rd(ad_cnt, 1'b1, w2);
        check(hi, c[15:8]);
        check(w2, w1 + 16'h0131);
        $display("test counter reads done");
        // Compare set by bytes with toggling off, then a match and a full wrap
        wr(ad_mode, 1'b0, 16'h0001);
        rd(ad_cnt, 1'b1, w1);
        c = w1 + 16'h00C8;
        wr(`FTCC_ADDR_MATCH_LO, 1'b0, {8'h00, c[7:0]});
        wr(`FTCC_ADDR_MATCH_HI, 1'b0, {8'h00, c[15:8]});
        rd(`FTCC_ADDR_MATCH_LO, 1'b1, q);
        check(q, c);
        wr(ad_mode, 1'b0, 16'h0009);
        cpu_u.idle();
        wait_irq(300);
        check({match_irq, toggle_out_pin, toggle_out_oe}, 17'h7);
        wait_irq(70000);
        check(n, 17'h10000);
        rd(ad_mode, 1'b0, q);
        check(q, 16'h0049);
        wr(ad_mode, 1'b0, 16'h0009);
        rd(ad_mode, 1'b0, q);
        check(q, 16'h0009);
        $display("test match and wrap done");
        // Each edge selection sees a rising then a falling pin edge
        foreach (edges[i])
        begin
            wr(ad_mode, 1'b0, {10'h000, edges[i], 4'h1});
            for (int e = 0; e < 2; e++)
            begin
                rd(ad_cnt, 1'b1, w1);
                trigger_in_pin = !trigger_in_pin;
                cpu_u.idle();
                repeat (8) @(negedge clock);
                rd(`FTCC_ADDR_SNAP_LO, 1'b1, q);
                if (edges[i][e])
                    check({16'h0, (q - w1) inside {[16'h0003:16'h0005]}}, 17'h1);
                else
                    check(q, cap);
                cap = q;
            end
        end
        cpu_u.idle();
        $display("test capture done");
        // Prescaler free-runs, so any 256-cycle window holds an exact tick count
        foreach (steps[i])
        begin
            wr(ad_mode, 1'b0, {13'h0, i[1:0], 1'b1});
            rd(ad_cnt, 1'b1, w1);
            cpu_u.idle();
            repeat (255) @(negedge clock);
            rd(ad_cnt, 1'b1, w2);
            c = w2 - w1;
            check(c, steps[i]);
        end
        cpu_u.idle();
        $display("test dividers done");
        // Mid-run reset restores the compare value and quiets the outputs
        rst_n = 1'b0;
        @(negedge clock);
        check({14'h0, toggle_out_pin, toggle_out_oe, match_irq}, 17'h0);
        rst_n = 1'b1;
        rd(`FTCC_ADDR_MATCH_LO, 1'b1, q);
        check(q, `FTCC_RST_MATCH);
        rd(ad_cnt, 1'b1, q);
        check(q, 16'h0001);
        cpu_u.idle();
        $display("test mid-run reset done");
        report_and_stop();
    end
endmodule // test_free_running_timer_capture_compare
